/* File: logic/tmr_consts.svh */
/*
 offsets, field positions and reset values of the dual timer block.
 assumes inclusion by the timer design file and by the testbench.
*/
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// register byte offsets
`define TMR_MODE_OFS 8'h00
`define TMR_CTRL_OFS 8'h04
`define TMR_CNT0_OFS 8'h08
`define TMR_CNT1_OFS 8'h0c
`define TMR_STS_OFS 8'h10
`define TMR_MSK_OFS 8'h14
`define TMR_BAD_OFS 8'hff

// mode register nibble layout
`define TMR_QUAL_BIT 3
`define TMR_SRC_BIT 2
`define TMR_NIB1_LSB 4

// control register layout
`define TMR_OVF1_BIT 7
`define TMR_RUN1_BIT 6
`define TMR_OVF0_BIT 5
`define TMR_RUN0_BIT 4

// reset values and bus codes
`define TMR_MODE_RST 8'h00
`define TMR_SIZE_WORD 3'h2

`endif

/* File: logic/tmr_pkg.sv */
/*
 types of the dual timer block: modes, bus states, state records.
 assumes tmr_consts.svh for numbers.
*/
package tmr_pkg;

   typedef enum logic [1:0] {
      MODE_13 = 2'b00,
      MODE_16 = 2'b01,
      MODE_RELOAD = 2'b10,
      MODE_SPLIT = 2'b11
   } tmode_t;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_DATA = 1'b1
   } bus_st_t;

   typedef struct packed {
      logic pin_prev;
      logic tick;
   } qual_state_t;

   typedef struct packed {
      bus_st_t st;
      logic [7:0] addr;
      logic wr;
      logic [7:0] mode;
      logic run0;
      logic run1;
      logic tf0;
      logic tf1;
      logic [7:0] tl0;
      logic [7:0] th0;
      logic [7:0] tl1;
      logic [7:0] th1;
      logic [1:0] sts;
      logic [1:0] msk;
      logic irq;
      logic [31:0] rdata;
      logic ready;
      logic resp;
   } tmr_state_t;

endpackage

/* File: logic/count_qualify.sv */
/*
 count qualifier of one timer: turns run, gate and source into a tick.
 assumes pins already synchronous to mclk.
*/
module count_qualify
   import tmr_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic run,
   input wire logic qualify,
   input wire logic source,
   input wire logic gate_pin,
   input wire logic count_pin,
   output logic tick
);

   qual_state_t q;
   qual_state_t d;

   always_comb
   begin
      d = q;
      d.pin_prev = count_pin;
      d.tick = run & (~qualify | gate_pin) & (~source | (q.pin_prev & ~count_pin));
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         q <= '0;
      else
         q <= d;
   end

   assign tick = q.tick;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   chk_gate_block: assert property (qualify && !gate_pin |=> !tick)
      else $error("tick while gate pin low");
   chk_run_needed: assert property (run && !qualify && !source |=> tick)
      else $error("no tick with run set");
   chk_pin_event: assert property (
      run && !qualify && source |=> tick == $past(q.pin_prev && !count_pin))
      else $error("counter tick not tied to pin fall");

endmodule

/* File: logic/dual_timer.sv */
/*
 dual 16-bit timer/counter with mode register, ahb-lite register slave.
 assumes single word transfers, pins synchronous to mclk, one irq line.
*/
// How it works
// - with qualify set, a running timer counts only while its irq pin is high
// - source bit clear counts system clocks, set counts falls of the count pin
// - mode bits: 13-bit, 16-bit, 8-bit auto-reload, or split mode
// - split: timer 0 low byte own controls, high byte under timer 1 run
// - timer 1 in split mode holds its value
// - timer 0 fields in low nibble, timer 1 in high nibble
// - mode register is written and read as a whole byte only
// - run bits of timer 1 and 0 sit at control bits 6 and 4
// - overflow sets the flag; vectoring to the handler clears it
`include "tmr_consts.svh"

module dual_timer
   import tmr_pkg::*;
(
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic count_pin_zero,
   input wire logic count_pin_one,
   input wire logic external_irq_pin_zero,
   input wire logic external_irq_pin_one,
   input wire logic vector_ack_zero,
   input wire logic vector_ack_one,
   output logic irq
);

   tmr_state_t q;
   tmr_state_t d;
   logic [2:0] tick;
   logic [2:0] run_v;
   logic [2:0] qual_v;
   logic [2:0] src_v;
   logic [2:0] gate_v;
   logic [2:0] cpin_v;
   tmode_t m0;
   tmode_t m1;
   logic take;
   logic wr_now;
   logic wr_cnt0;
   logic wr_cnt1;
   logic ovf0;
   logic ovf1;
   logic [16:0] step0;
   logic [16:0] step1;
   logic [1:0] sts_clr;

   function automatic tmode_t mode_of(input logic [3:0] nib);
      return tmode_t'(nib[1:0]);
   endfunction

   // one count step: {overflow, high byte, low byte}
   function automatic logic [16:0] step(input tmode_t m, input logic [7:0] hi,
                                        input logic [7:0] lo);
      logic [16:0] r;
      r = {1'b0, hi, lo};
      case (m)
         MODE_13:
         begin
            if (lo[4:0] == 5'h1f)
               r = {&hi, hi + 8'h01, lo[7:5], 5'h00};
            else
               r = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
         end
         MODE_16:
            r = {1'b0, hi, lo} + 17'h00001;
         MODE_RELOAD:
            r = (&lo) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
         MODE_SPLIT:
            r = {&lo, hi, lo + 8'h01};
         default:
            r = {1'b0, hi, lo};
      endcase
      return r;
   endfunction

   assign m0 = mode_of(q.mode[3:0]);
   assign m1 = mode_of(q.mode[7:4]);

   assign run_v = {q.run1, q.run1, q.run0};
   assign qual_v = {q.mode[`TMR_NIB1_LSB + `TMR_QUAL_BIT], q.mode[`TMR_NIB1_LSB + `TMR_QUAL_BIT],
                    q.mode[`TMR_QUAL_BIT]};
   // split high byte is a timer only
   assign src_v = {1'b0, q.mode[`TMR_NIB1_LSB + `TMR_SRC_BIT], q.mode[`TMR_SRC_BIT]};
   assign gate_v = {external_irq_pin_one, external_irq_pin_one, external_irq_pin_zero};
   assign cpin_v = {1'b0, count_pin_one, count_pin_zero};

   // tick 0 timer 0, tick 1 timer 1, tick 2 split high byte
   generate
      for (genvar i = 0; i < 3; i++)
      begin : g_qual
         count_qualify u_qual (
            .mclk(mclk),
            .reset_n(reset_n),
            .run(run_v[i]),
            .qualify(qual_v[i]),
            .source(src_v[i]),
            .gate_pin(gate_v[i]),
            .count_pin(cpin_v[i]),
            .tick(tick[i])
         );
      end
   endgenerate

   assign take = hsel && htrans[1] && hready;
   assign wr_now = (q.st == BUS_DATA) && q.wr;
   assign wr_cnt0 = wr_now && (q.addr == `TMR_CNT0_OFS);
   assign wr_cnt1 = wr_now && (q.addr == `TMR_CNT1_OFS);
   assign step0 = step(m0, q.th0, q.tl0);
   assign step1 = step(m1, q.th1, q.tl1);

   always_comb
   begin
      d = q;
      d.resp = 1'b0;
      ovf0 = 1'b0;
      ovf1 = 1'b0;
      sts_clr = 2'b00;
      // timer 0 counting
      if (tick[0])
      begin
         {d.th0, d.tl0} = step0[15:0];
         ovf0 = step0[16];
      end
      // high byte runs under timer 1 run
      if (tick[2] && (m0 == MODE_SPLIT))
      begin
         d.th0 = q.th0 + 8'h01;
         ovf1 = &q.th0;
      end
      if (tick[1] && (m1 != MODE_SPLIT))
      begin
         {d.th1, d.tl1} = step1[15:0];
         if (m0 != MODE_SPLIT)
            ovf1 = step1[16];
      end
      // bus slave, one wait state per transfer
      case (q.st)
         BUS_IDLE:
         begin
            if (take)
            begin
               d.st = BUS_DATA;
               d.wr = hwrite;
               d.ready = 1'b0;
               if ((haddr[31:8] == 24'h000000) && (hsize == `TMR_SIZE_WORD))
                  d.addr = haddr[7:0];
               else
                  d.addr = `TMR_BAD_OFS;
            end
         end
         BUS_DATA:
         begin
            d.st = BUS_IDLE;
            d.ready = 1'b1;
            if (q.wr)
            begin
               case (q.addr)
                  `TMR_MODE_OFS:
                     d.mode = hwdata[7:0];
                  `TMR_CTRL_OFS:
                  begin
                     d.run1 = hwdata[`TMR_RUN1_BIT];
                     d.run0 = hwdata[`TMR_RUN0_BIT];
                  end
                  `TMR_CNT0_OFS:
                     {d.th0, d.tl0} = hwdata[15:0];
                  `TMR_CNT1_OFS:
                     {d.th1, d.tl1} = hwdata[15:0];
                  `TMR_STS_OFS:
                     sts_clr = hwdata[1:0];
                  `TMR_MSK_OFS:
                     d.msk = hwdata[1:0];
                  default:
                     d.msk = q.msk;
               endcase
            end
            else
            begin
               case (q.addr)
                  `TMR_MODE_OFS:
                     d.rdata = {24'h000000, q.mode};
                  `TMR_CTRL_OFS:
                     d.rdata = {24'h000000, q.tf1, q.run1, q.tf0, q.run0, 4'h0};
                  `TMR_CNT0_OFS:
                     d.rdata = {16'h0000, q.th0, q.tl0};
                  `TMR_CNT1_OFS:
                     d.rdata = {16'h0000, q.th1, q.tl1};
                  `TMR_STS_OFS:
                     d.rdata = {30'h00000000, q.sts};
                  `TMR_MSK_OFS:
                     d.rdata = {30'h00000000, q.msk};
                  default:
                     d.rdata = 32'h00000000;
               endcase
            end
         end
         default:
         begin
            d.st = BUS_IDLE;
            d.ready = 1'b1;
         end
      endcase
      // flag set wins over vector clear
      d.tf0 = (q.tf0 & ~vector_ack_zero) | ovf0;
      d.tf1 = (q.tf1 & ~vector_ack_one) | ovf1;
      d.sts = (q.sts & ~sts_clr) | {ovf1, ovf0};
      d.irq = |(d.sts & d.msk);
   end

   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         q <= '0;
         q.mode <= `TMR_MODE_RST;
         q.ready <= 1'b1;
      end
      else
         q <= d;
   end

   assign hrdata = q.rdata;
   assign hreadyout = q.ready;
   assign hresp = q.resp;
   assign irq = q.irq;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);

   sequence s_take;
      (q.st == BUS_IDLE) && take;
   endsequence

   sequence s_mode_write;
      wr_now && (q.addr == `TMR_MODE_OFS);
   endsequence

   sequence s_ctrl_write;
      wr_now && (q.addr == `TMR_CTRL_OFS);
   endsequence

   sequence s_sts_write;
      wr_now && (q.addr == `TMR_STS_OFS);
   endsequence

   chk_bus_answer: assert property (s_take |=> !hreadyout ##1 hreadyout)
      else $error("slave answer not after one wait state");
   chk_mode_whole: assert property (s_mode_write |=> q.mode == $past(hwdata[7:0]))
      else $error("mode register not written as a byte");
   chk_run_ctrl: assert property (s_ctrl_write |=>
      q.run1 == $past(hwdata[6]) && q.run0 == $past(hwdata[4]))
      else $error("run bits not at control bits 6 and 4");
   chk_split_hold: assert property ((m1 == MODE_SPLIT) && !wr_cnt1 |=>
      $stable({q.th1, q.tl1}))
      else $error("timer 1 moved in split mode");
   chk_count_sixteen: assert property (tick[0] && (m0 == MODE_16) && !wr_cnt0 |=>
      {q.th0, q.tl0} == $past({q.th0, q.tl0}) + 16'h0001)
      else $error("sixteen-bit count wrong");
   chk_reload_low: assert property (tick[0] && (m0 == MODE_RELOAD) && (&q.tl0) &&
      !wr_cnt0 |=> q.tl0 == $past(q.th0) && $stable(q.th0) && q.tf0)
      else $error("auto-reload failed");
   chk_split_high: assert property (tick[2] && (m0 == MODE_SPLIT) && !wr_cnt0 |=>
      q.th0 == $past(q.th0) + 8'h01)
      else $error("split high byte not counting");
   chk_ovf_flag: assert property (ovf0 |=>
      q.tf0 && q.sts[0] && (irq == |(q.sts & q.msk)))
      else $error("overflow flag or irq missing");
   chk_ovf_one: assert property (ovf1 |=> q.tf1 && q.sts[1])
      else $error("timer 1 overflow flag missing");
   chk_vector_clear: assert property (vector_ack_zero && !ovf0 |=> !q.tf0)
      else $error("vector ack did not clear flag");
   chk_sts_clear: assert property (
      s_sts_write ##0 (hwdata[0] && !ovf0) |=> !q.sts[0])
      else $error("status bit not cleared by write");
   chk_mode13_low: assert property (tick[0] && (m0 == MODE_13) && !wr_cnt0 |=>
      $stable(q.tl0[7:5]))
      else $error("thirteen-bit count moved upper low bits");

endmodule

/* File: verification/pin_source.sv */
/*
 far-side pin model: count pins idle high, gate pins follow requests.
 assumes requests change just after rising edges of mclk.
*/
module pin_source
(
   input wire logic mclk,
   input wire logic gate0,
   input wire logic gate1,
   input wire logic pulse0,
   input wire logic pulse1,
   output logic count_pin_zero,
   output logic count_pin_one,
   output logic external_irq_pin_zero,
   output logic external_irq_pin_one
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      count_pin_zero = 1'b1;
      count_pin_one = 1'b1;
      external_irq_pin_zero = 1'b0;
      external_irq_pin_one = 1'b0;
      // pins change one cycle after each request
      forever
      begin
         @(posedge mclk);
         count_pin_zero <= ~pulse0;
         count_pin_one <= ~pulse1;
         external_irq_pin_zero <= gate0;
         external_irq_pin_one <= gate1;
      end
   end
endmodule

/* File: verification/dual_timer_tb.sv */
/*
 self-checking bench of dual_timer over ahb-lite.
 assumes pin_source on the pin side and the offsets of tmr_consts.svh.
*/
`include "tmr_consts.svh"

module dual_timer_tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic mclk, reset_n, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, v;
   logic [1:0] htrans;
   logic gate0, gate1, pulse0, pulse1, ack0, ack1;
   logic cp0, cp1, gp0, gp1;
   int err_count, comparisons;
   logic [7:0] modes[3] = '{8'h00, 8'h01, 8'h02};
   logic [15:0] pre[3] = '{16'hffff, 16'hffff, 16'h40ff};
   logic [15:0] post[3] = '{16'h00e8, 16'h0008, 16'h4048};

   dual_timer dual_timer_i (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .count_pin_zero(cp0),
      .count_pin_one(cp1), .external_irq_pin_zero(gp0), .external_irq_pin_one(gp1),
      .vector_ack_zero(ack0), .vector_ack_one(ack1), .irq(irq));

   pin_source pin_source_i (.mclk(mclk), .gate0(gate0), .gate1(gate1), .pulse0(pulse0),
      .pulse1(pulse1), .count_pin_zero(cp0), .count_pin_one(cp1),
      .external_irq_pin_zero(gp0), .external_irq_pin_one(gp1));

   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task end_sim;
      if (err_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task wait_rdy;
      int n;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1)
      begin
         err_count++;
         end_sim;
      end
   endtask

   task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy;
      v = hrdata;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   task rdc(input logic [7:0] a, input logic [31:0] exp);
      xfer(a, 1'b0, 32'h0);
      chk(v, exp);
   endtask

   task t_reset;
      rdc(`TMR_MODE_OFS, 32'h0);
      rdc(`TMR_CTRL_OFS, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      wr(`TMR_BAD_OFS, 32'hff);
      rdc(`TMR_BAD_OFS, 32'h0);
      rdc(`TMR_MODE_OFS, 32'h0);
   endtask

   task t_mode;
      wr(`TMR_MODE_OFS, 32'h69);
      rdc(`TMR_MODE_OFS, 32'h69);
      cyc(5);
      rdc(`TMR_CNT0_OFS, 32'h0);
   endtask

   task t_gate;
      wr(`TMR_MODE_OFS, 32'h09);
      wr(`TMR_CTRL_OFS, 32'h10);
      cyc(8);
      rdc(`TMR_CNT0_OFS, 32'h0);
      gate0 <= 1'b1;
      cyc(5);
      gate0 <= 1'b0;
      cyc(5);
      rdc(`TMR_CNT0_OFS, 32'h5);
      wr(`TMR_CTRL_OFS, 32'h0);
   endtask

   task t_count(input logic t);
      wr(`TMR_MODE_OFS, t ? 32'h50 : 32'h05);
      wr(t ? `TMR_CNT1_OFS : `TMR_CNT0_OFS, 32'h0);
      wr(`TMR_CTRL_OFS, t ? 32'h40 : 32'h10);
      cyc(6);
      repeat (3)
      begin
         if (t) pulse1 <= 1'b1;
         else pulse0 <= 1'b1;
         cyc(1);
         pulse0 <= 1'b0;
         pulse1 <= 1'b0;
         cyc(3);
      end
      cyc(4);
      rdc(t ? `TMR_CNT1_OFS : `TMR_CNT0_OFS, 32'h3);
      wr(`TMR_CTRL_OFS, 32'h0);
   endtask

   task t_ovf;
      wr(`TMR_MSK_OFS, 32'h1);
      for (int i = 0; i < 3; i++)
      begin
         wr(`TMR_MODE_OFS, {24'h0, modes[i]});
         wr(`TMR_CNT0_OFS, {16'h0, pre[i]});
         wr(`TMR_CTRL_OFS, 32'h10);
         cyc(6);
         wr(`TMR_CTRL_OFS, 32'h0);
         rdc(`TMR_CTRL_OFS, 32'h20);
         rdc(`TMR_STS_OFS, 32'h1);
         chk({31'h0, irq}, 32'h1);
         xfer(`TMR_CNT0_OFS, 1'b0, 32'h0);
         chk({16'h0, v[15:0]}, {16'h0, post[i]});
         ack0 <= 1'b1;
         cyc(1);
         ack0 <= 1'b0;
         rdc(`TMR_CTRL_OFS, 32'h0);
         wr(`TMR_MSK_OFS, 32'h0);
         cyc(2);
         chk({31'h0, irq}, 32'h0);
         wr(`TMR_MSK_OFS, 32'h1);
         wr(`TMR_STS_OFS, 32'h1);
         cyc(2);
         chk({31'h0, irq}, 32'h0);
         rdc(`TMR_STS_OFS, 32'h0);
      end
   endtask

   task t_ovf1;
      wr(`TMR_MSK_OFS, 32'h2);
      wr(`TMR_MODE_OFS, 32'h90);
      wr(`TMR_CNT1_OFS, 32'hffff);
      wr(`TMR_CTRL_OFS, 32'h40);
      cyc(6);
      rdc(`TMR_CNT1_OFS, 32'hffff);
      gate1 <= 1'b1;
      cyc(5);
      gate1 <= 1'b0;
      cyc(5);
      rdc(`TMR_CNT1_OFS, 32'h4);
      rdc(`TMR_CTRL_OFS, 32'hc0);
      rdc(`TMR_STS_OFS, 32'h2);
      chk({31'h0, irq}, 32'h1);
      ack1 <= 1'b1;
      cyc(1);
      ack1 <= 1'b0;
      rdc(`TMR_CTRL_OFS, 32'h40);
      wr(`TMR_STS_OFS, 32'h2);
      wr(`TMR_CTRL_OFS, 32'h0);
      chk({31'h0, irq}, 32'h0);
   endtask

   task t_split;
      wr(`TMR_MODE_OFS, 32'h33);
      wr(`TMR_CNT0_OFS, 32'h0);
      wr(`TMR_CNT1_OFS, 32'h1234);
      wr(`TMR_CTRL_OFS, 32'h40);
      cyc(6);
      wr(`TMR_CTRL_OFS, 32'h0);
      xfer(`TMR_CNT0_OFS, 1'b0, 32'h0);
      chk({24'h0, v[7:0]}, 32'h0);
      chk({24'h0, v[15:8]}, 32'h9);
      rdc(`TMR_CNT1_OFS, 32'h1234);
   endtask

   initial
   begin
      {reset_n, hsel, hwrite, gate0, gate1, pulse0, pulse1, ack0, ack1} = '0;
      {haddr, hwdata, htrans} = '0;
      err_count = 0;
      comparisons = 0;
      cyc(10);
      reset_n <= 1'b1;
      t_reset;
      t_mode;
      t_gate;
      t_count(1'b0);
      t_count(1'b1);
      t_ovf;
      t_ovf1;
      t_split;
      end_sim;
   end
endmodule
